// ### rtl/program_counter_return_stack.sv
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module program_counter_return_stack
	import pc_stack_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	input  wire logic [REG_ADDR_W-1:0] reg_addr,
	input  wire logic [BYTE_W-1:0]     reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output      logic [BYTE_W-1:0]     reg_rdata,
	input  wire logic                  seq_step,
	input  wire logic                  branch_load,
	input  wire logic [PC_W-1:0]       branch_target,
	input  wire logic                  call_req,
	input  wire logic [PC_W-1:0]       call_target,
	input  wire logic                  int_ack,
	input  wire logic                  int_high,
	input  wire logic                  ret_req,
	output      logic [PC_W-1:0]       fetch_addr,
	input  wire logic [WORD_W-1:0]     fetch_data_in,
	output      logic [WORD_W-1:0]     fetch_word,
	output      logic                  fault_reset
);

	////////////////////////////////////////////////////////////////////////////
	logic [PC_W-1:0]    pc_ff;
	logic [BYTE_W-1:0]  pc_high_latch_ff;
	logic [UPPER_W-1:0] pc_upper_latch_ff;
	logic [SP_W-1:0]    return_stack_pointer_ff;
	logic               stack_overflow_flag_ff;
	logic               stack_underflow_flag_ff;
	logic               stack_fault_reset_enable_ff;
	logic [BYTE_W-1:0]  reg_rdata_ff;
	logic [WORD_W-1:0]  fetch_word_ff;
	logic               fault_reset_ff;

	logic [PC_W-1:0]    nxt_pc;
	logic [SP_W-1:0]    nxt_sp;
	logic               nxt_ovf;
	logic               nxt_unf;
	logic               fault_now;
	pc_src_t            pc_src;
	logic [PC_W-1:0]    top_of_stack;

	logic sw_wr_ctrl;
	logic core_push;
	logic core_pop;
	logic sw_push;
	logic sw_pop;
	logic push_any;
	logic pop_any;
	logic push_ok;
	logic pop_ok;
	logic tos_wr;

	stack_mem_if mem_bus ();

	return_stack_ram u_ram (
		.clock  (clock),
		.rst_b  (rst_b),
		.port_m (mem_bus.mem)
	);

	function automatic logic wr_hit(input logic [REG_ADDR_W-1:0] offset);
		return reg_wr && (reg_addr == offset);
	endfunction

	function automatic logic [PC_W-1:0] align(input logic [PC_W-1:0] value);
		return {value[PC_W-1:1], 1'b0};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// stack operation decode; core requests outrank software ones
	// procedural on purpose: the decode function reads the bus from module scope,
	// which a continuous assignment would not re-evaluate on
	always_comb begin
		sw_wr_ctrl = wr_hit(REG_STACK_CTRL);
	end
	assign core_push  = call_req || int_ack;
	assign core_pop   = ret_req && !core_push;
	assign sw_push    = sw_wr_ctrl && reg_wdata[SW_PUSH_BIT] && !core_push && !core_pop;
	assign sw_pop     = sw_wr_ctrl && reg_wdata[SW_POP_BIT] && !core_push && !core_pop
		&& !reg_wdata[SW_PUSH_BIT];
	assign push_any   = core_push || sw_push;
	assign pop_any    = core_pop || sw_pop;
	// a full stack refuses further pushes so the last entry survives
	assign push_ok    = push_any && (return_stack_pointer_ff != SP_FULL);
	assign pop_ok     = pop_any && (return_stack_pointer_ff != SP_EMPTY);
	always_comb begin
		tos_wr = (wr_hit(REG_TOS_LOW) || wr_hit(REG_TOS_HIGH) || wr_hit(REG_TOS_UPPER))
			&& !push_any && !pop_any && (return_stack_pointer_ff != SP_EMPTY);
	end
	assign top_of_stack = (return_stack_pointer_ff == SP_EMPTY) ? '0 : mem_bus.rd_data;

	// the fault reset fires on the push that fills the stack or any push onto a full one, or on any empty pop
	assign fault_now = stack_fault_reset_enable_ff
		&& ((push_any && (return_stack_pointer_ff >= (SP_FULL - SP_ONE)))
		|| (pop_any && !pop_ok));

	always_comb begin
		nxt_sp  = return_stack_pointer_ff;
		nxt_ovf = stack_overflow_flag_ff;
		nxt_unf = stack_underflow_flag_ff;
		// software clear comes first so a same-cycle hardware set still wins
		if (wr_hit(REG_STACK_PTR)) begin
			nxt_ovf = stack_overflow_flag_ff && reg_wdata[OVF_BIT];
			nxt_unf = stack_underflow_flag_ff && reg_wdata[UNF_BIT];
			if (!push_any && !pop_any) begin
				nxt_sp = reg_wdata[SP_W-1:0];
			end
		end
		if (push_ok) begin
			nxt_sp = return_stack_pointer_ff + SP_ONE;
			if (nxt_sp == SP_FULL) begin
				nxt_ovf = 1'b1;
			end
		end else if (push_any) begin
			nxt_ovf = 1'b1;
		end
		if (pop_ok) begin
			nxt_sp = return_stack_pointer_ff - SP_ONE;
		end else if (pop_any) begin
			nxt_unf = 1'b1;
		end
		if (fault_now) begin
			nxt_sp = SP_EMPTY;
		end
	end

	// entry n of the pointer lives at ram index n-1; pointer zero has no storage
	always_comb begin
		mem_bus.wr_en    = 1'b0;
		mem_bus.wr_index = return_stack_pointer_ff;
		mem_bus.wr_data  = pc_ff;
		if (push_ok) begin
			mem_bus.wr_en = 1'b1;
		end else if (tos_wr) begin
			mem_bus.wr_en    = 1'b1;
			mem_bus.wr_index = return_stack_pointer_ff - SP_ONE;
			mem_bus.wr_data  = mem_bus.rd_data;
			case (reg_addr)
				REG_TOS_LOW: begin
					mem_bus.wr_data[BYTE_W-1:0] = reg_wdata;
				end
				REG_TOS_HIGH: begin
					mem_bus.wr_data[2*BYTE_W-1:BYTE_W] = reg_wdata;
				end
				default: begin
					mem_bus.wr_data[PC_W-1:2*BYTE_W] = reg_wdata[UPPER_W-1:0];
				end
			endcase
		end
		mem_bus.rd_index = nxt_sp - SP_ONE;
	end

	////////////////////////////////////////////////////////////////////////////
	// program counter source selection
	always_comb begin
		pc_src = PC_HOLD;
		if (fault_now) begin
			pc_src = PC_FAULT;
		end else if (int_ack) begin
			pc_src = PC_VECTOR;
		end else if (call_req) begin
			pc_src = PC_CALL;
		end else if (core_pop) begin
			pc_src = PC_RETURN;
		end else if (branch_load) begin
			pc_src = PC_BRANCH;
		end else if (wr_hit(REG_PC_LOW)) begin
			pc_src = PC_SOFT;
		end else if (seq_step) begin
			pc_src = PC_SEQ;
		end
	end

	always_comb begin
		case (pc_src)
			PC_FAULT:  nxt_pc = RESET_VECTOR;
			PC_VECTOR: nxt_pc = int_high ? HIGH_VECTOR : LOW_VECTOR;
			PC_CALL:   nxt_pc = call_target;
			PC_RETURN: nxt_pc = top_of_stack;
			PC_BRANCH: nxt_pc = branch_target;
			PC_SOFT:   nxt_pc = {pc_upper_latch_ff, pc_high_latch_ff, reg_wdata};
			PC_SEQ:    nxt_pc = PC_W'(pc_ff + PC_STEP);
			default:   nxt_pc = pc_ff;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pc_ff <= RESET_VECTOR;
		end else begin
			pc_ff <= align(nxt_pc);
		end
	end

	// latches change by software access or a fault reset; call and return paths touch them only through that fault reset
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pc_high_latch_ff  <= '0;
			pc_upper_latch_ff <= '0;
		end else if (fault_now) begin
			pc_high_latch_ff  <= '0;
			pc_upper_latch_ff <= '0;
		end else if (reg_rd && (reg_addr == REG_PC_LOW)) begin
			pc_high_latch_ff  <= pc_ff[2*BYTE_W-1:BYTE_W];
			pc_upper_latch_ff <= pc_ff[PC_W-1:2*BYTE_W];
		end else begin
			if (wr_hit(REG_HIGH_LATCH)) begin
				pc_high_latch_ff <= reg_wdata;
			end
			if (wr_hit(REG_UPPER_LATCH)) begin
				pc_upper_latch_ff <= reg_wdata[UPPER_W-1:0];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			return_stack_pointer_ff <= SP_EMPTY;
			stack_overflow_flag_ff  <= 1'b0;
			stack_underflow_flag_ff <= 1'b0;
		end else begin
			return_stack_pointer_ff <= nxt_sp;
			stack_overflow_flag_ff  <= nxt_ovf;
			stack_underflow_flag_ff <= nxt_unf;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stack_fault_reset_enable_ff <= FAULT_EN_RESET;
		end else if (sw_wr_ctrl) begin
			stack_fault_reset_enable_ff <= reg_wdata[FAULT_EN_BIT];
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fault_reset_ff <= 1'b0;
		end else begin
			fault_reset_ff <= fault_now;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fetch path: the memory answers combinationally for fetch_addr
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fetch_word_ff <= '0;
		end else if (pc_ff >= PROG_MEM_BYTES) begin
			fetch_word_ff <= '0;
		end else begin
			fetch_word_ff <= fetch_data_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register read; high and upper counter bytes are read through the latches that a low-byte read fills
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_ff <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_PC_LOW:      reg_rdata_ff <= pc_ff[BYTE_W-1:0];
				REG_HIGH_LATCH:  reg_rdata_ff <= pc_high_latch_ff;
				REG_UPPER_LATCH: reg_rdata_ff <= {3'h0, pc_upper_latch_ff};
				REG_STACK_PTR:   reg_rdata_ff <= {stack_overflow_flag_ff, stack_underflow_flag_ff,
					1'b0, return_stack_pointer_ff};
				REG_TOS_LOW:     reg_rdata_ff <= top_of_stack[BYTE_W-1:0];
				REG_TOS_HIGH:    reg_rdata_ff <= top_of_stack[2*BYTE_W-1:BYTE_W];
				REG_TOS_UPPER:   reg_rdata_ff <= {3'h0, top_of_stack[PC_W-1:2*BYTE_W]};
				default:         reg_rdata_ff <= {7'h00, stack_fault_reset_enable_ff};
			endcase
		end else begin
			reg_rdata_ff <= '0;
		end
	end

	assign reg_rdata   = reg_rdata_ff;
	assign fetch_addr  = pc_ff;
	assign fetch_word  = fetch_word_ff;
	assign fault_reset = fault_reset_ff;

	////////////////////////////////////////////////////////////////////////////
	a_lsb_zero: assert property (@(posedge clock) disable iff (!rst_b)
		pc_ff[0] == 1'b0) else $error("counter bit zero set");

	a_step_by_two: assert property (@(posedge clock) disable iff (!rst_b)
		(pc_src == PC_SEQ) |=> pc_ff == PC_W'($past(pc_ff) + PC_STEP))
		else $error("sequential step not two");

	a_low_write_latch: assert property (@(posedge clock) disable iff (!rst_b)
		(pc_src == PC_SOFT) |=>
		pc_ff[PC_W-1:BYTE_W] == $past({pc_upper_latch_ff, pc_high_latch_ff}))
		else $error("latches not copied on low byte write");

	a_low_read_copy: assert property (@(posedge clock) disable iff (!rst_b)
		(reg_rd && reg_addr == REG_PC_LOW && !fault_now) |=>
		pc_high_latch_ff == $past(pc_ff[2*BYTE_W-1:BYTE_W])
		&& reg_rdata == $past(pc_ff[BYTE_W-1:0]))
		else $error("low byte read did not copy upper bytes");

	a_call_keeps_latch: assert property (@(posedge clock) disable iff (!rst_b)
		((core_push || core_pop) && !reg_wr && !reg_rd && !fault_now) |=>
		$stable(pc_high_latch_ff) && $stable(pc_upper_latch_ff))
		else $error("call or return changed a latch");

	a_push_then_top: assert property (@(posedge clock) disable iff (!rst_b)
		(push_ok && core_push && !fault_now) |=>
		return_stack_pointer_ff == SP_W'($past(return_stack_pointer_ff) + SP_ONE)
		&& top_of_stack == $past(pc_ff))
		else $error("push did not store above old pointer");

	a_empty_pop: assert property (@(posedge clock) disable iff (!rst_b)
		(core_pop && return_stack_pointer_ff == SP_EMPTY) |=>
		stack_underflow_flag_ff && pc_ff == RESET_VECTOR && return_stack_pointer_ff == SP_EMPTY)
		else $error("empty pop mishandled");

	a_full_holds: assert property (@(posedge clock) disable iff (!rst_b)
		(push_any && return_stack_pointer_ff == SP_FULL && !stack_fault_reset_enable_ff) |=>
		return_stack_pointer_ff == SP_FULL && stack_overflow_flag_ff && $stable(top_of_stack))
		else $error("full stack pointer or entry moved");

	a_fault_resets: assert property (@(posedge clock) disable iff (!rst_b)
		(push_any && return_stack_pointer_ff == SP_FULL - SP_ONE && stack_fault_reset_enable_ff)
		|=> fault_reset && stack_overflow_flag_ff && return_stack_pointer_ff == SP_EMPTY
		&& pc_ff == RESET_VECTOR)
		else $error("fault reset did not act");

	a_vector_pick: assert property (@(posedge clock) disable iff (!rst_b)
		(int_ack && !fault_now) |=> pc_ff == ($past(int_high) ? HIGH_VECTOR : LOW_VECTOR))
		else $error("wrong interrupt vector");

	a_fetch_zero: assert property (@(posedge clock) disable iff (!rst_b)
		(pc_ff >= PROG_MEM_BYTES) |=> fetch_word == '0)
		else $error("fetch beyond memory not zero");

endmodule

// ### rtl/pc_stack_pkg.sv
package pc_stack_pkg;

	localparam int PC_W        = 21;
	localparam int SP_W        = 5;
	localparam int BYTE_W      = 8;
	localparam int UPPER_W     = 5;
	localparam int REG_ADDR_W  = 3;
	localparam int WORD_W      = 16;
	localparam int STACK_DEPTH = 31;

	localparam logic [PC_W-1:0] RESET_VECTOR   = 21'h000000;
	localparam logic [PC_W-1:0] HIGH_VECTOR    = 21'h000008;
	localparam logic [PC_W-1:0] LOW_VECTOR     = 21'h000018;
	localparam logic [PC_W-1:0] PC_STEP        = 21'h000002;
	localparam logic [PC_W-1:0] PROG_MEM_BYTES = 21'h004000;

	localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;
	localparam logic [SP_W-1:0] SP_FULL  = 5'h1f;
	localparam logic [SP_W-1:0] SP_ONE   = 5'h01;

	// register map, one byte each
	localparam logic [REG_ADDR_W-1:0] REG_PC_LOW       = 3'h0;
	localparam logic [REG_ADDR_W-1:0] REG_HIGH_LATCH   = 3'h1;
	localparam logic [REG_ADDR_W-1:0] REG_UPPER_LATCH  = 3'h2;
	localparam logic [REG_ADDR_W-1:0] REG_STACK_PTR    = 3'h3;
	localparam logic [REG_ADDR_W-1:0] REG_TOS_LOW      = 3'h4;
	localparam logic [REG_ADDR_W-1:0] REG_TOS_HIGH     = 3'h5;
	localparam logic [REG_ADDR_W-1:0] REG_TOS_UPPER    = 3'h6;
	localparam logic [REG_ADDR_W-1:0] REG_STACK_CTRL   = 3'h7;

	localparam int OVF_BIT      = 7;
	localparam int UNF_BIT      = 6;
	localparam int FAULT_EN_BIT = 0;
	localparam int SW_PUSH_BIT  = 1;
	localparam int SW_POP_BIT   = 2;

	localparam logic FAULT_EN_RESET = 1'b1;

	typedef enum {
		PC_HOLD, PC_FAULT, PC_VECTOR, PC_CALL, PC_RETURN, PC_BRANCH, PC_SOFT, PC_SEQ
	} pc_src_t;

endpackage

// ### rtl/stack_mem_if.sv
`timescale 1ns/1ps
interface stack_mem_if;
	import pc_stack_pkg::*;

	logic              wr_en;
	logic [SP_W-1:0]   wr_index;
	logic [PC_W-1:0]   wr_data;
	logic [SP_W-1:0]   rd_index;
	logic [PC_W-1:0]   rd_data;

	modport ctrl (output wr_en, output wr_index, output wr_data, output rd_index, input rd_data);
	modport mem  (input wr_en, input wr_index, input wr_data, input rd_index, output rd_data);
endinterface

// ### rtl/return_stack_ram.sv
`timescale 1ns/1ps
module return_stack_ram
	import pc_stack_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_b,
	stack_mem_if.mem  port_m
);

	logic [PC_W-1:0] entry_mem [STACK_DEPTH];
	logic [PC_W-1:0] rd_data_ff;

	always_ff @(posedge clock) begin
		if (port_m.wr_en) begin
			entry_mem[port_m.wr_index] <= port_m.wr_data;
		end
	end

	// forward a same-cycle write so the read register always mirrors the addressed entry
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_ff <= '0;
		end else if (port_m.wr_en && (port_m.wr_index == port_m.rd_index)) begin
			rd_data_ff <= port_m.wr_data;
		end else begin
			rd_data_ff <= entry_mem[port_m.rd_index];
		end
	end

	assign port_m.rd_data = rd_data_ff;

endmodule

// ### testbench/prog_mem_model.sv
`timescale 1ns/1ps
// program memory stand-in: bit 0 of each word is set, so every word is nonzero
// and a zeroed fetch beyond the implemented memory can be told apart
module prog_mem_model
	import pc_stack_pkg::*;
(
	input  wire logic [PC_W-1:0]   fetch_addr,
	output      logic [WORD_W-1:0] fetch_data_in
);
	assign fetch_data_in = fetch_addr[WORD_W-1:0] ^ 16'h8001;
endmodule

// ### testbench/program_counter_return_stack_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module program_counter_return_stack_tb_top;
	import pc_stack_pkg::*;

	typedef struct {
		int              op;
		logic [PC_W-1:0] arg;
		logic [PC_W-1:0] pc;
	} row_t;

	logic                  clock;
	logic                  rst_b;
	logic [REG_ADDR_W-1:0] reg_addr;
	logic [BYTE_W-1:0]     reg_wdata;
	logic                  reg_wr;
	logic                  reg_rd;
	logic [BYTE_W-1:0]     reg_rdata;
	logic                  seq_step;
	logic                  branch_load;
	logic [PC_W-1:0]       branch_target;
	logic                  call_req;
	logic [PC_W-1:0]       call_target;
	logic                  int_ack;
	logic                  int_high;
	logic                  ret_req;
	logic [PC_W-1:0]       fetch_addr;
	logic [WORD_W-1:0]     fetch_data_in;
	logic [WORD_W-1:0]     fetch_word;
	logic                  fault_reset;
	int                    n_fail;
	int                    check_count;
	int                    fault_cnt;
	int                    fr;
	// ops: 0 step, 1 branch, 2 call, 3 high int, 4 low int, 5 return
	row_t                  rows [10] = '{
		'{0, 21'h0, 21'h000002}, '{0, 21'h0, 21'h000004},
		'{1, 21'h012345, 21'h012344}, '{2, 21'h000100, 21'h000100},
		'{3, 21'h0, 21'h000008}, '{4, 21'h0, 21'h000018},
		'{5, 21'h0, 21'h000008}, '{5, 21'h0, 21'h000100},
		'{5, 21'h0, 21'h012344}, '{5, 21'h0, 21'h000000}};

	program_counter_return_stack dut (
		.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_step(seq_step),
		.branch_load(branch_load), .branch_target(branch_target), .call_req(call_req),
		.call_target(call_target), .int_ack(int_ack), .int_high(int_high),
		.ret_req(ret_req), .fetch_addr(fetch_addr), .fetch_data_in(fetch_data_in),
		.fetch_word(fetch_word), .fault_reset(fault_reset));

	prog_mem_model mem (.fetch_addr(fetch_addr), .fetch_data_in(fetch_data_in));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	always @(posedge clock) begin
		if (fault_reset === 1'b1)
			fault_cnt++;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rdc(input logic [REG_ADDR_W-1:0] a, input logic [BYTE_W-1:0] e);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask

	task automatic core(input int op, input logic [PC_W-1:0] arg);
		@(posedge clock);
		case (op)
			0: seq_step <= 1'b1;
			1: begin
				branch_load   <= 1'b1;
				branch_target <= arg;
			end
			2: begin
				call_req    <= 1'b1;
				call_target <= arg;
			end
			3, 4: begin
				int_ack  <= 1'b1;
				int_high <= (op == 3);
			end
			default: ret_req <= 1'b1;
		endcase
		@(posedge clock);
		{seq_step, branch_load, call_req, int_ack, ret_req} <= 5'h00;
		#1;
	endtask

	initial begin
		#20000;
		n_fail++;
		stop_test();
	end

	initial begin
		{rst_b, reg_wr, reg_rd, seq_step, branch_load, call_req, int_ack, int_high} = 8'h00;
		{reg_addr, reg_wdata, ret_req} = 12'h000;
		{branch_target, call_target} = 42'h0;
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		#1;
		`CHK(fetch_addr, RESET_VECTOR)
		`CHK(reg_rdata, 8'h00)
		rdc(REG_STACK_PTR, 8'h00);
		rdc(REG_STACK_CTRL, 8'h01);
		@(posedge clock);
		#1;
		`CHK(reg_rdata, 8'h00)
		$display("reset test done");

		foreach (rows[i]) begin
			core(rows[i].op, rows[i].arg);
			`CHK(fetch_addr, rows[i].pc)
		end
		rdc(REG_STACK_PTR, 8'h40);
		wr(REG_STACK_PTR, 8'h00);
		rdc(REG_STACK_PTR, 8'h00);
		$display("table test done");

		wr(REG_HIGH_LATCH, 8'h12);
		wr(REG_UPPER_LATCH, 8'h03);
		wr(REG_PC_LOW, 8'h35);
		#1;
		`CHK(fetch_addr, 21'h031234)
		core(1, 21'h0abcd1);
		@(posedge clock);
		#1;
		`CHK(fetch_word, 16'h0000)
		rdc(REG_PC_LOW, 8'hd0);
		rdc(REG_HIGH_LATCH, 8'hbc);
		rdc(REG_UPPER_LATCH, 8'h0a);
		core(2, 21'h000200);
		@(posedge clock);
		#1;
		`CHK(fetch_word, 16'h8201)
		rdc(REG_HIGH_LATCH, 8'hbc);
		rdc(REG_TOS_LOW, 8'hd0);
		rdc(REG_TOS_HIGH, 8'hbc);
		rdc(REG_TOS_UPPER, 8'h0a);
		core(5, 21'h0);
		`CHK(fetch_addr, 21'h0abcd0)
		rdc(REG_UPPER_LATCH, 8'h0a);
		$display("latch test done");

		// software push of the current counter, then overwrite and discard it
		wr(REG_STACK_CTRL, 8'h03);
		rdc(REG_STACK_PTR, 8'h01);
		wr(REG_TOS_LOW, 8'h44);
		rdc(REG_TOS_LOW, 8'h44);
		wr(REG_TOS_UPPER, 8'hfb);
		rdc(REG_TOS_UPPER, 8'h1b);
		wr(REG_STACK_CTRL, 8'h05);
		rdc(REG_STACK_PTR, 8'h00);
		$display("software stack test done");

		wr(REG_STACK_CTRL, 8'h00);
		for (int i = 1; i <= 32; i++)
			core(2, 21'(i * 4));
		rdc(REG_STACK_PTR, 8'h9f);
		rdc(REG_TOS_LOW, 8'h78);
		$display("overflow hold test done");

		wr(REG_STACK_PTR, 8'h00);
		wr(REG_STACK_CTRL, 8'h01);
		fr = fault_cnt;
		for (int i = 1; i <= 31; i++)
			core(2, 21'(i * 4));
		repeat (3) @(posedge clock);
		#1;
		`CHK(fault_cnt - fr, 1)
		`CHK(fetch_addr, RESET_VECTOR)
		rdc(REG_STACK_PTR, 8'h80);
		$display("overflow fault test done");

		// a second power-on reset mid-run must empty the stack and drop the flags
		core(2, 21'h000040);
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rdc(REG_STACK_PTR, 8'h00);
		$display("second reset test done");
		stop_test();
	end
endmodule
